// ==== tpw_pkg.sv ====
// Purpose: Shared constants and carrier types for the pulse/PWM timer
// Assumes: One 100 MHz clock, synchronous active-low reset
// Notes:   Mode codes follow the three-bit mode select field
package tpw_pkg;
  localparam int unsigned CNT_W       = 16;
  localparam logic [2:0]  MODE_TRIG   = 3'h2;
  localparam logic [2:0]  MODE_ONESHOT = 3'h3;
  localparam logic [2:0]  MODE_PWM    = 3'h4;
  localparam logic [2:0]  MODE_FREE   = 3'h5;
  localparam logic [15:0] CNT_IDLE    = 16'hffff;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
  localparam logic [15:0] CMP_RST     = 16'h0000;
  localparam real         CLK_NS      = 10.0;
  localparam real         SYNC_NS     = 20.0;
  localparam int unsigned SYNC_CYC    = int'(SYNC_NS / CLK_NS);

  // Software control of the timer
  typedef struct packed {
    logic       count_enable_bit;
    logic [2:0] mode_select_field;
    logic       soft_trigger_bit;
    logic       event_clock_select;
    logic       slot0_capture_select;
    logic       slot1_capture_select;
  } tpw_ctrl_t;

  // Register write strobes with data
  typedef struct packed {
    logic        cycle_wr;
    logic        duty_wr;
    logic [15:0] wdata;
  } tpw_wr_t;

  // Compare match events
  typedef struct packed {
    logic cycle_match;
    logic duty_match;
  } tpw_irq_t;
endpackage

// ==== tpw_timer.sv ====
// Purpose: 16-bit up counter with triggered pulse, one-shot, PWM and
//          free-running mode select, two compare slots and two outputs
// Assumes: Count clock equals mclk; trigger pin is synchronous
// Notes:   Capture paths of free-running mode are not implemented
`timescale 1ns/1ps
`default_nettype none
module tpw_timer
  import tpw_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire tpw_pkg::tpw_ctrl_t  ctrl,
  input  wire tpw_pkg::tpw_wr_t    wr,
  input  wire logic                trigger_input_pin,
  output logic                     pulse_output,
  output logic                     toggle_output,
  output tpw_pkg::tpw_irq_t        match_irq,
  output logic [15:0]              count_value,
  output logic                     running
);
  import tpw_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN, ST_DONE} tpw_state_t;

  tpw_state_t  state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] cyc_reg_q, duty_reg_q;
  logic [15:0] cyc_buf_q, duty_buf_q;
  logic        cyc_wr_seen_q, reload_arm_q;
  logic        trig_q, pulse_q, tog_q;
  tpw_irq_t    irq_q;

  // Mode decode
  wire logic mode_trig = ctrl.mode_select_field == MODE_TRIG;
  wire logic mode_one  = ctrl.mode_select_field == MODE_ONESHOT;
  wire logic mode_pwm  = ctrl.mode_select_field == MODE_PWM;
  wire logic mode_free = ctrl.mode_select_field == MODE_FREE;
  wire logic reload_md = mode_trig | mode_pwm;
  wire logic en        = ctrl.count_enable_bit;
  // Compare selection: capture select only honoured in free-running
  wire logic cmp0_on = ~(mode_free & ctrl.slot0_capture_select);
  wire logic cmp1_on = ~(mode_free & ctrl.slot1_capture_select);

  // Trigger edge from pin or software bit
  wire logic pin_edge  = trigger_input_pin & ~trig_q;
  wire logic trig_ev   = pin_edge | ctrl.soft_trigger_bit;
  wire logic counting  = state_q == ST_RUN;
  wire logic cyc_hit   = counting & (cnt_q == cyc_buf_q);
  wire logic duty_hit  = counting & (cnt_q == duty_buf_q);
  wire logic do_reload = reload_md & cyc_hit & reload_arm_q;

  // Sequencing of counter state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (!en) begin
      state_d = ST_IDLE;
      cnt_d   = CNT_ZERO;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (mode_trig || mode_one) begin
            state_d = ST_WAIT;
            cnt_d   = CNT_IDLE;
          end else begin
            state_d = ST_RUN;
            cnt_d   = CNT_ZERO;
          end
        end
        ST_WAIT: begin
          if (trig_ev) begin
            state_d = ST_RUN;
            cnt_d   = CNT_ZERO;
          end
        end
        ST_RUN: begin
          if (mode_trig && trig_ev) begin
            cnt_d = CNT_ZERO;
          end else if (mode_one && cyc_hit) begin
            cnt_d   = CNT_ZERO;
            state_d = ST_DONE;
          end else if ((mode_pwm || mode_trig) && cyc_hit) begin
            cnt_d = CNT_ZERO;
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
        end
        ST_DONE: begin
          if (mode_one && trig_ev) begin
            state_d = ST_RUN;
            cnt_d   = CNT_ZERO;
          end
        end
        default: begin
          state_d = ST_IDLE;
          cnt_d   = CNT_ZERO;
        end
      endcase
    end
  end

  // Counter and state registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      cnt_q   <= CNT_ZERO;
      trig_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      trig_q  <= trigger_input_pin;
    end
  end

  // Register writes and reload arming
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cyc_reg_q     <= CMP_RST;
      duty_reg_q    <= CMP_RST;
      cyc_wr_seen_q <= 1'b0;
      reload_arm_q  <= 1'b0;
    end else begin
      if (wr.cycle_wr) cyc_reg_q <= wr.wdata;
      if (wr.duty_wr) duty_reg_q <= wr.wdata;
      if (do_reload) begin
        cyc_wr_seen_q <= wr.cycle_wr;
        reload_arm_q  <= 1'b0;
      end else begin
        if (wr.cycle_wr) cyc_wr_seen_q <= 1'b1;
        if (wr.duty_wr) reload_arm_q <= cyc_wr_seen_q | wr.cycle_wr;
      end
    end
  end

  // Compare buffers: reload in triggered/PWM while enabled, anytime write otherwise
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cyc_buf_q  <= CMP_RST;
      duty_buf_q <= CMP_RST;
    end else if (reload_md && en) begin
      if (do_reload) begin
        cyc_buf_q  <= cyc_reg_q;
        duty_buf_q <= duty_reg_q;
      end
    end else begin
      if (wr.cycle_wr) cyc_buf_q <= wr.wdata;
      if (wr.duty_wr) duty_buf_q <= wr.wdata;
    end
  end

  // Pulse and toggle outputs
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pulse_q <= 1'b0;
      tog_q   <= 1'b0;
      irq_q   <= '0;
    end else begin
      irq_q.cycle_match <= cyc_hit & cmp0_on;
      irq_q.duty_match  <= duty_hit & cmp1_on;
      if (!en || state_q != ST_RUN) begin
        if (!en) pulse_q <= 1'b0;
      end else if (cyc_hit) begin
        tog_q <= cmp0_on ? ~tog_q : tog_q;
        if (mode_one) pulse_q <= 1'b0;
        // Wrap leaves the rise to the zero count: high for duty clocks
        else if (reload_md) pulse_q <= pulse_q & ~duty_hit;
      end else if (duty_hit && cmp1_on) begin
        if (mode_one) pulse_q <= 1'b1;
        else if (reload_md) pulse_q <= 1'b0;
        else pulse_q <= ~pulse_q;
      end else if (reload_md && cnt_q == CNT_ZERO) begin
        pulse_q <= duty_buf_q != CNT_ZERO;
      end
    end
  end

  assign pulse_output  = pulse_q;
  assign toggle_output = tog_q;
  assign match_irq     = irq_q;
  assign count_value   = cnt_q;
  assign running       = counting;

  // Start-up: in triggered and one-shot modes enable parks the counter, a trigger releases it
  a_wait_hold_ones: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_q == ST_WAIT && en && !trig_ev) |=> cnt_q == CNT_IDLE)
    else $error("Counter left all ones while waiting");
  a_idle_park: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_q == ST_IDLE && en && (mode_trig || mode_one))
      |=> state_q == ST_WAIT && cnt_q == CNT_IDLE)
    else $error("Counter not parked at all ones");
  a_pin_start: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_q == ST_WAIT && en && pin_edge)
      |=> counting && cnt_q == CNT_ZERO)
    else $error("Pin edge did not start the counter");
  a_soft_start: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_q == ST_WAIT && en && ctrl.soft_trigger_bit)
      |=> counting && cnt_q == CNT_ZERO)
    else $error("Soft trigger did not start the counter");

  // Counter sequencing while running
  a_retrig_clear: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (counting && mode_trig && trig_ev && en) |=> cnt_q == CNT_ZERO)
    else $error("Retrigger did not clear counter");
  a_oneshot_stop: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (counting && mode_one && cyc_hit && en) |=> state_q == ST_DONE
      && cnt_q == CNT_ZERO ##1 !pulse_output)
    else $error("One-shot did not stop at zero");
  a_done_park: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_q == ST_DONE && en && !trig_ev)
      |=> state_q == ST_DONE && cnt_q == CNT_ZERO)
    else $error("Stopped one-shot moved without a trigger");
  a_oneshot_ignore: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (counting && mode_one && trig_ev && !cyc_hit && en)
      |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("One-shot retriggered while running");
  a_duty_noclear: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (counting && duty_hit && !cyc_hit && !trig_ev && en)
      |=> cnt_q != CNT_ZERO || $past(cnt_q) == CNT_IDLE)
    else $error("Duty match cleared counter");
  a_pwm_wrap: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (counting && en && mode_pwm && cyc_hit) |=> cnt_q == CNT_ZERO)
    else $error("PWM counter did not wrap at cycle match");
  a_free_count: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (counting && en && mode_free) |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("Free-running counter did not advance");
  a_stop_disable: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !en |=> !running && cnt_q == CNT_ZERO)
    else $error("Timer ran with enable clear");

  // Output waveforms
  a_toggle_match: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (cyc_hit && cmp0_on && en) |=> toggle_output != $past(toggle_output))
    else $error("Toggle output missed cycle match");
  a_toggle_quiet: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !(cyc_hit && cmp0_on && en) |=> $stable(toggle_output))
    else $error("Toggle output moved without a cycle match");
  a_pulse_fall: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (counting && en && reload_md && duty_hit) |=> !pulse_output)
    else $error("Pulse stayed high past the duty match");
  a_pulse_rise: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (counting && en && reload_md && cnt_q == CNT_ZERO && !cyc_hit
      && !duty_hit && duty_buf_q != CNT_ZERO) |=> pulse_output)
    else $error("Pulse did not rise at the period start");
  a_oneshot_rise: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (counting && en && mode_one && duty_hit && !cyc_hit) |=> pulse_output)
    else $error("One-shot pulse did not rise at duty match");
  a_pulse_off: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !en |=> !pulse_output)
    else $error("Pulse high with enable clear");

  // Compare buffers: batch reload or direct write
  a_reload_both: assert property (
    @(posedge mclk) disable iff (!rst_b)
    do_reload && en |=> cyc_buf_q == $past(cyc_reg_q)
      && duty_buf_q == $past(duty_reg_q))
    else $error("Reload did not move both values");
  a_reload_hold: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (reload_md && en && !do_reload)
      |=> $stable(cyc_buf_q) && $stable(duty_buf_q))
    else $error("Buffer changed without an armed reload");
  a_direct_cycle: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (!(reload_md && en) && wr.cycle_wr) |=> cyc_buf_q == $past(wr.wdata))
    else $error("Cycle write did not reach its buffer");
  a_direct_duty: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (!(reload_md && en) && wr.duty_wr) |=> duty_buf_q == $past(wr.wdata))
    else $error("Duty write did not reach its buffer");

  // Compare or capture selection and match requests
  a_compare_fixed: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !mode_free |-> cmp0_on && cmp1_on)
    else $error("Compare slot disabled outside free-running");
  a_capture_quiet0: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (mode_free && ctrl.slot0_capture_select) |=> !match_irq.cycle_match)
    else $error("Capture slot zero raised a match");
  a_capture_quiet1: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (mode_free && ctrl.slot1_capture_select) |=> !match_irq.duty_match)
    else $error("Capture slot one raised a match");
  a_irq_match: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (duty_hit && cmp1_on) |=> match_irq.duty_match)
    else $error("Duty match request missing");
  a_irq_cycle: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (cyc_hit && cmp0_on) |=> match_irq.cycle_match)
    else $error("Cycle match request missing");

  // Main scenarios reached
  c_pwm_period: cover property (@(posedge mclk) disable iff (!rst_b)
    mode_pwm && cyc_hit ##[1:40] cyc_hit);
  c_soft_start: cover property (@(posedge mclk) disable iff (!rst_b)
    state_q == ST_WAIT && ctrl.soft_trigger_bit);
  c_oneshot_done: cover property (@(posedge mclk) disable iff (!rst_b)
    mode_one && state_q == ST_DONE);
  c_retrigger: cover property (@(posedge mclk) disable iff (!rst_b)
    mode_trig && counting && trig_ev);
  c_reload: cover property (@(posedge mclk) disable iff (!rst_b)
    do_reload);
endmodule
`default_nettype wire

// ==== tpw_trig_src.sv ====
// Purpose: Model of the external trigger source on the trigger pin
// Assumes: Pin is driven push-pull and idles low
// Notes:   Fires one rising edge after a chosen lag, only on request
`timescale 1ns/1ps
`default_nettype none
module tpw_trig_src (
  input  wire logic       mclk,
  input  wire logic       fire,
  input  wire logic [3:0] lag,
  output var  logic       trig
);
  initial trig = 1'b0;
  // Wait the lag, then hold the pin high for two clocks
  always @(posedge mclk) begin
    if (fire) begin
      repeat (lag) @(posedge mclk);
      trig <= 1'b1;
      repeat (2) @(posedge mclk);
      trig <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the pulse/PWM timer
// Assumes: 100 MHz clock, synchronous active-low reset
// Notes:   Waveforms judged by counts over whole periods
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  import tpw_pkg::*;
  logic        mclk, rst_b, trig, fire, pulse_output, toggle_output, running;
  logic [3:0]  lag;
  logic [15:0] count_value;
  tpw_ctrl_t   ctrl;
  tpw_wr_t     wr;
  tpw_irq_t    match_irq;
  int          n_fail, samples_checked, hi, flips, dm, mx, nz, wz;
  tpw_timer tpw_timer_i (.mclk(mclk), .rst_b(rst_b), .ctrl(ctrl), .wr(wr),
    .trigger_input_pin(trig), .pulse_output(pulse_output),
    .toggle_output(toggle_output), .match_irq(match_irq),
    .count_value(count_value), .running(running));
  tpw_trig_src tpw_trig_src_i (.mclk(mclk), .fire(fire), .lag(lag),
    .trig(trig));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic close_out;
    $display("checks=%0d failures=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic put(input logic cw, dw, input logic [15:0] v);
    wr <= '{cycle_wr: cw, duty_wr: dw, wdata: v};
    tick();
    wr <= '0;
    tick();
  endtask
  task automatic pulse_soft;
    ctrl.soft_trigger_bit <= 1'b1;
    tick();
    ctrl.soft_trigger_bit <= 1'b0;
  endtask
  task automatic pulse_pin(input logic [3:0] l);
    fire <= 1'b1;
    lag <= l;
    tick();
    fire <= 1'b0;
  endtask
  // Bounded wait for the counter to read zero
  task automatic wait_zero;
    int i;
    for (i = 0; i < 64 && count_value !== CNT_ZERO; i++) tick();
    wz = i;
    if (i == 64) begin
      n_fail++;
      close_out();
    end
  endtask
  // Tally output activity over n clocks
  task automatic measure(input int n);
    logic t0;
    {hi, flips, dm, mx, nz} = '0;
    t0 = toggle_output;
    repeat (n) begin
      tick();
      hi += int'(pulse_output);
      flips += int'(toggle_output !== t0);
      t0 = toggle_output;
      dm += int'(match_irq.duty_match);
      nz += int'(count_value !== CNT_ZERO);
      if (int'(count_value) > mx) mx = int'(count_value);
    end
  endtask
  // Load cycle then duty with the timer stopped, then start it
  task automatic setup(input logic [2:0] m, input logic [15:0] c, d);
    ctrl.count_enable_bit <= 1'b0;
    ctrl.mode_select_field <= m;
    tick();
    put(1'b1, 1'b0, c);
    put(1'b0, 1'b1, d);
    ctrl.count_enable_bit <= 1'b1;
    tick(3);
  endtask
  task automatic sc_trig;
    setup(MODE_TRIG, 16'h0014, 16'h0003);
    `CHK(count_value, CNT_IDLE)
    pulse_pin(4'h0);
    wait_zero();
    tick(4);
    `CHK(count_value, 16'h0004)
    pulse_soft();
    wait_zero();
    `CHK(wz < 4, 1'b1)
    tick(3);
    pulse_pin(4'h3);
    wait_zero();
    `CHK(wz < 8, 1'b1)
    measure(21);
    `CHK(hi, 3)
    `CHK(flips, 1)
    `CHK(mx, 20)
  endtask
  task automatic sc_oneshot;
    logic t0;
    setup(MODE_ONESHOT, 16'h0003, 16'h0001);
    put(1'b1, 1'b0, 16'h0006);
    put(1'b0, 1'b1, 16'h0002);
    `CHK(count_value, CNT_IDLE)
    t0 = toggle_output;
    pulse_soft();
    wait_zero();
    // Trigger while running must be ignored
    pulse_pin(4'h1);
    measure(12);
    `CHK(hi, 4)
    // Count one passes during the pin request, so five nonzero counts
    `CHK(nz, 5)
    `CHK(count_value, CNT_ZERO)
    `CHK(pulse_output, 1'b0)
    `CHK(toggle_output, ~t0)
  endtask
  task automatic sc_pwm;
    setup(MODE_PWM, 16'h0003, 16'h0001);
    measure(8);
    `CHK(hi, 2)
    `CHK(flips, 2)
    `CHK(mx, 3)
    `CHK(dm, 2)
    put(1'b1, 1'b0, 16'h0005);
    tick(8);
    measure(8);
    `CHK(mx, 3)
    put(1'b0, 1'b1, 16'h0002);
    tick(8);
    measure(12);
    `CHK(hi, 4)
    `CHK(flips, 2)
    `CHK(mx, 5)
    ctrl.count_enable_bit <= 1'b0;
    tick(2);
    `CHK(count_value, CNT_ZERO)
  endtask
  task automatic sc_free;
    setup(MODE_FREE, 16'h0003, 16'h0001);
    measure(16);
    `CHK(mx > 3, 1'b1)
    `CHK(dm, 0)
  endtask
  // Main sequence; capture selects stay set outside free-running too
  initial begin
    rst_b = 1'b0;
    fire = 1'b0;
    lag = 4'h0;
    wr = '0;
    ctrl = '0;
    ctrl.slot0_capture_select = 1'b1;
    ctrl.slot1_capture_select = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    tick(10);
    rst_b <= 1'b1;
    tick();
    `CHK(count_value, CNT_ZERO)
    `CHK({pulse_output, toggle_output}, 2'h0)
    sc_trig();
    sc_oneshot();
    sc_pwm();
    sc_free();
    close_out();
  end
endmodule
`default_nettype wire
